//--- logic/nvram_pkg.sv
// Function
// - 8192 byte array, eight bits each
// - accept SPI mode 0 and mode 3
// - select high: standby, ignore inputs, tristate
// - clock reaches logic only while selected
// - sample on rise, drive on fall
// - clock half period of 25 ns or more, pauses keep state
// - serial input sampled only on rises
// - each data byte written at once
// - protect pin, write disable, block protection
// - first byte after select is command
// - two address bytes, top three ignored
// - output driven only while returning data
// - suspend input freezes clock and select
package nvram_pkg;

    // ---------------------------------------------
    // array geometry
    // ---------------------------------------------
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 8192;
    localparam int FIFO_DEPTH = 32;
    localparam int ADDR_HI_W = ADDR_W - DATA_W;

    // ---------------------------------------------
    // command codes
    // ---------------------------------------------
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_WREN = 8'h06;

    // ---------------------------------------------
    // status byte layout and protection
    // ---------------------------------------------
    localparam int SR_WEL_BIT = 1;
    localparam int SR_BP_LO = 2;
    localparam int SR_BP_HI = 3;
    localparam int SR_WPEN_BIT = 7;
    localparam logic [1:0] BP_NONE = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF = 2'h2;
    localparam logic [1:0] BP_ALL = 2'h3;
    localparam logic [12:0] QUARTER_BASE = 13'h1800;
    localparam logic [12:0] HALF_BASE = 13'h1000;
    localparam logic [1:0] BP_RESET = 2'h0;
    localparam logic WEL_RESET = 1'b0;
    localparam logic WPEN_RESET = 1'b0;

    // ---------------------------------------------
    // pin vector indices
    // ---------------------------------------------
    localparam int PIN_CS = 0;
    localparam int PIN_SCK = 1;
    localparam int PIN_SI = 2;
    localparam int PIN_HOLD = 3;
    localparam int PIN_WP = 4;
    localparam int PIN_N = 5;
    localparam int BIT_LAST = 7;

    // ---------------------------------------------
    // link timing
    // ---------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int SCK_HALF_MIN_NS = 25;
    localparam int SCK_HALF_MIN_CYC = SCK_HALF_MIN_NS / CLK_PERIOD_NS;

    typedef enum {
        ST_OPCODE,
        ST_ADDR_HI,
        ST_ADDR_LO,
        ST_READ,
        ST_WRITE,
        ST_STATUS_RD,
        ST_STATUS_WR,
        ST_IGNORE
    } phase_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } wr_req_t;

endpackage

//--- logic/req_fifo.sv
`timescale 1ns/10ps
module req_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 32
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_q;
    logic [AW:0] rd_ptr_q;
    logic push;
    logic pop;

    assign o_valid = wr_ptr_q != rd_ptr_q;
    assign o_ready = !((wr_ptr_q[AW] != rd_ptr_q[AW])
                       && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]));
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;
    assign o_data = mem[rd_ptr_q[AW-1:0]];

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr_q[AW-1:0]] <= i_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
        end
    end
endmodule

//--- logic/byte_array.sv
`timescale 1ns/10ps
module byte_array #(
    parameter int ADDR_W = 13,
    parameter int DATA_W = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_we,
    input wire logic [ADDR_W-1:0] i_waddr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_re,
    input wire logic [ADDR_W-1:0] i_raddr,
    output logic [DATA_W-1:0] o_rdata
);
    // contents are never reset: they model nonvolatile storage
    logic [DATA_W-1:0] mem [2**ADDR_W];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= '0;
        end else if (i_re) begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule

//--- logic/serial_nvram_spi_front_end.sv
`timescale 1ns/10ps
module serial_nvram_spi_front_end (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_cs_b,
    input wire logic i_sck,
    input wire logic i_si,
    input wire logic i_hold_b,
    input wire logic i_wp_b,
    output logic o_so,
    output logic o_so_oe,
    output logic o_standby,
    output logic o_overrun
);
    import nvram_pkg::*;

    // ---------------------------------------------
    // pin synchronisers
    // ---------------------------------------------
    logic [PIN_N-1:0] pins_raw;
    logic [PIN_N-1:0] sync1_q;
    logic [PIN_N-1:0] sync2_q;

    assign pins_raw[PIN_CS] = i_cs_b;
    assign pins_raw[PIN_SCK] = i_sck;
    assign pins_raw[PIN_SI] = i_si;
    assign pins_raw[PIN_HOLD] = i_hold_b;
    assign pins_raw[PIN_WP] = i_wp_b;

    for (genvar g = 0; g < PIN_N; g++) begin : g_sync
        always_ff @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                sync1_q[g] <= 1'b1;
                sync2_q[g] <= 1'b1;
            end else begin
                sync1_q[g] <= pins_raw[g];
                sync2_q[g] <= sync1_q[g];
            end
        end
    end

    logic sck_s;
    logic si_s;
    logic hold_b_s;
    logic wp_b_s;

    assign sck_s = sync2_q[PIN_SCK];
    assign si_s = sync2_q[PIN_SI];
    assign hold_b_s = sync2_q[PIN_HOLD];
    assign wp_b_s = sync2_q[PIN_WP];

    // ---------------------------------------------
    // select and clock gating
    // ---------------------------------------------
    logic cs_eff_q;
    logic sck_prev_q;
    logic active;
    logic rise;
    logic fall;

    // select changes are not seen while suspended
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cs_eff_q <= 1'b1;
        end else if (hold_b_s) begin
            cs_eff_q <= sync2_q[PIN_CS];
        end
    end

    // the previous level is tracked even when gated, so leaving
    // suspend or standby never fabricates an edge
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sck_prev_q <= 1'b1;
        end else begin
            sck_prev_q <= sck_s;
        end
    end

    assign active = !cs_eff_q && hold_b_s;
    // edge detection works with either idle level of the clock
    assign rise = active && sck_s && !sck_prev_q;
    assign fall = active && !sck_s && sck_prev_q;

    // ---------------------------------------------
    // input shifter
    // ---------------------------------------------
    logic [DATA_W-1:0] in_shift_q;
    logic [2:0] bit_cnt_q;
    logic byte_done;
    logic [DATA_W-1:0] rx_byte;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            in_shift_q <= '0;
            bit_cnt_q <= '0;
        end else if (cs_eff_q) begin
            bit_cnt_q <= '0;
        end else if (rise) begin
            in_shift_q <= {in_shift_q[DATA_W-2:0], si_s};
            bit_cnt_q <= bit_cnt_q + 3'h1;
        end
    end

    // edges only count at the sample rate; nothing depends on
    // the link period, so a stopped clock just waits
    assign byte_done = rise && (bit_cnt_q == 3'(BIT_LAST));
    assign rx_byte = {in_shift_q[DATA_W-2:0], si_s};

    // ---------------------------------------------
    // status and protection
    // ---------------------------------------------
    logic wel_q;
    logic wpen_q;
    logic [1:0] bp_q;
    logic [DATA_W-1:0] status;
    phase_t phase_q;
    logic [ADDR_W-1:0] addr_q;

    always_comb begin
        status = '0;
        status[SR_WEL_BIT] = wel_q;
        status[SR_BP_HI:SR_BP_LO] = bp_q;
        status[SR_WPEN_BIT] = wpen_q;
    end

    function automatic logic is_protected(
        input logic [1:0] bp,
        input logic [ADDR_W-1:0] a
    );
        logic hit;
        hit = 1'b0;
        case (bp)
            BP_NONE: hit = 1'b0;
            BP_QUARTER: hit = a >= QUARTER_BASE;
            BP_HALF: hit = a >= HALF_BASE;
            BP_ALL: hit = 1'b1;
            default: hit = 1'b1;
        endcase
        return hit;
    endfunction

    logic status_wr_ok;
    logic data_wr_ok;

    // the protect pin only guards the status byte when armed
    assign status_wr_ok = wel_q && !(wpen_q && !wp_b_s);
    assign data_wr_ok = wel_q && !is_protected(bp_q, addr_q);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wel_q <= WEL_RESET;
            wpen_q <= WPEN_RESET;
            bp_q <= BP_RESET;
        end else if (byte_done) begin
            if (phase_q == ST_OPCODE && rx_byte == OP_WREN) begin
                wel_q <= 1'b1;
            end
            if (phase_q == ST_OPCODE && rx_byte == OP_WRDI) begin
                wel_q <= 1'b0;
            end
            if (phase_q == ST_STATUS_WR && status_wr_ok) begin
                bp_q <= rx_byte[SR_BP_HI:SR_BP_LO];
                wpen_q <= rx_byte[SR_WPEN_BIT];
            end
        end
    end

    // ---------------------------------------------
    // command sequencer
    // ---------------------------------------------
    logic is_read_q;
    logic fetch_q;
    logic [ADDR_W-1:0] fetch_addr_q;
    logic [ADDR_W-1:0] full_addr;

    assign full_addr = {addr_q[ADDR_W-1:DATA_W], rx_byte};

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            phase_q <= ST_OPCODE;
            is_read_q <= 1'b0;
            addr_q <= '0;
        end else if (cs_eff_q) begin
            phase_q <= ST_OPCODE;
        end else if (byte_done) begin
            case (phase_q)
                ST_OPCODE: begin
                    is_read_q <= rx_byte == OP_READ;
                    case (rx_byte)
                        OP_READ: phase_q <= ST_ADDR_HI;
                        OP_WRITE: phase_q <= ST_ADDR_HI;
                        OP_RDSR: phase_q <= ST_STATUS_RD;
                        OP_WRSR: phase_q <= ST_STATUS_WR;
                        default: phase_q <= ST_IGNORE;
                    endcase
                end
                ST_ADDR_HI: begin
                    // top bits of the first address byte are dropped
                    addr_q[ADDR_W-1:DATA_W] <= rx_byte[ADDR_HI_W-1:0];
                    phase_q <= ST_ADDR_LO;
                end
                ST_ADDR_LO: begin
                    if (is_read_q) begin
                        addr_q <= full_addr + 1'b1;
                        phase_q <= ST_READ;
                    end else begin
                        addr_q[DATA_W-1:0] <= rx_byte;
                        phase_q <= ST_WRITE;
                    end
                end
                ST_READ: addr_q <= addr_q + 1'b1;
                ST_WRITE: addr_q <= addr_q + 1'b1;
                ST_STATUS_WR: phase_q <= ST_IGNORE;
                ST_STATUS_RD: phase_q <= ST_STATUS_RD;
                ST_IGNORE: phase_q <= ST_IGNORE;
                default: phase_q <= ST_IGNORE;
            endcase
        end
    end

    // read fetch runs one byte ahead; the array answers long
    // before the falling edge that first needs the byte
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fetch_q <= 1'b0;
            fetch_addr_q <= '0;
        end else begin
            fetch_q <= 1'b0;
            if (byte_done && phase_q == ST_ADDR_LO && is_read_q) begin
                fetch_q <= 1'b1;
                fetch_addr_q <= full_addr;
            end else if (byte_done && phase_q == ST_READ) begin
                fetch_q <= 1'b1;
                fetch_addr_q <= addr_q;
            end
        end
    end

    // ---------------------------------------------
    // write path through the buffer
    // ---------------------------------------------
    wr_req_t push_req;
    wr_req_t drain_req;
    logic push_valid;
    logic push_ready;
    logic drain_valid;
    logic drain_ready;
    logic overrun_q;
    logic [DATA_W-1:0] rd_data;

    assign push_req.addr = addr_q;
    assign push_req.data = rx_byte;
    assign push_valid = byte_done && phase_q == ST_WRITE && data_wr_ok;
    // reads own the array port; queued writes wait a cycle
    assign drain_ready = !fetch_q;

    req_fifo #(
        .WIDTH($bits(wr_req_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_valid(push_valid),
        .o_ready(push_ready),
        .i_data(push_req),
        .o_valid(drain_valid),
        .i_ready(drain_ready),
        .o_data(drain_req)
    );

    byte_array #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W)
    ) u_array (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_we(drain_valid && drain_ready),
        .i_waddr(drain_req.addr),
        .i_wdata(drain_req.data),
        .i_re(fetch_q),
        .i_raddr(fetch_addr_q),
        .o_rdata(rd_data)
    );

    // the host cannot be stalled, so a byte refused by a full
    // buffer is lost and flagged until the first clock rise of the next selection
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            overrun_q <= 1'b0;
        end else if (push_valid && !push_ready) begin
            overrun_q <= 1'b1;
        end else if (cs_eff_q && rise) begin
            overrun_q <= 1'b0;
        end else if (!cs_eff_q && bit_cnt_q == 3'h0 && phase_q == ST_OPCODE
                     && rise) begin
            overrun_q <= 1'b0;
        end
    end

    // ---------------------------------------------
    // output shifter
    // ---------------------------------------------
    logic [DATA_W-1:0] out_shift_q;
    logic so_q;
    logic tx_on_q;
    logic reading;
    logic [DATA_W-1:0] tx_src;

    assign reading = phase_q == ST_READ || phase_q == ST_STATUS_RD;
    assign tx_src = (phase_q == ST_STATUS_RD) ? status : rd_data;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            out_shift_q <= '0;
            so_q <= 1'b0;
            tx_on_q <= 1'b0;
        end else if (cs_eff_q) begin
            tx_on_q <= 1'b0;
        end else if (fall && reading) begin
            tx_on_q <= 1'b1;
            if (bit_cnt_q == 3'h0) begin
                so_q <= tx_src[DATA_W-1];
                out_shift_q <= {tx_src[DATA_W-2:0], 1'b0};
            end else begin
                so_q <= out_shift_q[DATA_W-1];
                out_shift_q <= {out_shift_q[DATA_W-2:0], 1'b0};
            end
        end
    end

    // ---------------------------------------------
    // registered pins
    // ---------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_so <= 1'b0;
            o_so_oe <= 1'b0;
            o_standby <= 1'b1;
            o_overrun <= 1'b0;
        end else begin
            o_so <= so_q;
            o_so_oe <= tx_on_q && active && reading;
            o_standby <= cs_eff_q;
            o_overrun <= overrun_q;
        end
    end
endmodule

//--- sim/serial_nvram_spi_front_end_assertions.sv
`timescale 1ns/10ps
module serial_nvram_spi_front_end_assertions (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_cs_b,
    input wire logic i_sck,
    input wire logic i_si,
    input wire logic i_hold_b,
    input wire logic i_wp_b,
    input wire logic o_so,
    input wire logic o_so_oe,
    input wire logic o_standby,
    input wire logic o_overrun
);
    logic sck_q;
    logic [3:0] fall_age_q;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    // ------------------------------------------
    // cycles since the serial clock pin fell
    // ------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sck_q <= 1'b0;
            fall_age_q <= 4'hf;
        end else begin
            sck_q <= i_sck;
            if (sck_q && !i_sck) begin
                fall_age_q <= 4'h0;
            end else if (fall_age_q != 4'hf) begin
                fall_age_q <= fall_age_q + 4'h1;
            end
        end
    end

    chk_standby_idle: assert property (
        (i_cs_b && i_hold_b) [*6] |-> o_standby && !o_so_oe)
        else $error("standby or output enable wrong while deselected");
    chk_active_sel: assert property (
        (!i_cs_b && i_hold_b) [*6] |-> !o_standby)
        else $error("standby still high while selected");
    chk_hold_tristate: assert property (
        (!i_hold_b) [*6] |-> !o_so_oe)
        else $error("serial output driven during suspend");
    chk_so_on_fall: assert property (
        o_so_oe && $changed(o_so) |-> fall_age_q inside {[1:6]})
        else $error("serial output moved without a clock fall");
    chk_oe_rise_fall: assert property (
        $rose(o_so_oe) |-> fall_age_q inside {[1:6]})
        else $error("output enable rose without a clock fall");
    chk_oe_needs_sel: assert property (
        o_so_oe |-> !$past(i_cs_b, 8))
        else $error("output enabled long after deselect");
    chk_no_write_drop: assert property (
        o_overrun == 1'b0)
        else $error("a write byte was dropped");
    chk_reset_idle: assert property (
        $rose(i_rst_b) |-> o_standby && !o_so_oe)
        else $error("outputs not idle after reset");

    cover property ($rose(o_so_oe));
    cover property (!i_hold_b && !i_cs_b);
    cover property ($fell(i_cs_b) && i_sck);
endmodule

bind serial_nvram_spi_front_end serial_nvram_spi_front_end_assertions
    u_serial_nvram_spi_front_end_assertions (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_cs_b(i_cs_b), .i_sck(i_sck),
    .i_si(i_si), .i_hold_b(i_hold_b), .i_wp_b(i_wp_b), .o_so(o_so),
    .o_so_oe(o_so_oe), .o_standby(o_standby), .o_overrun(o_overrun));

//--- sim/spi_host_model.sv
`timescale 1ns/10ps
module spi_host_model (
    input wire logic i_clk,
    input wire logic i_so,
    input wire logic i_so_oe,
    output logic o_cs_b,
    output logic o_sck,
    output logic o_si,
    output logic o_hold_b,
    output logic o_wp_b
);
    // half of the 125 ns link period; the link clock runs free of
    // the system clock, so its edges land anywhere in a cycle
    localparam realtime HALF = 62.5;
    logic si_q = 1'b0;
    logic idle_q = 1'b0;

    initial begin
        o_cs_b = 1'b1;
        o_sck = 1'b0;
        o_hold_b = 1'b1;
        o_wp_b = 1'b1;
    end

    // released data line toggles so a stale level never looks valid
    always_ff @(posedge i_clk) begin
        idle_q <= ~idle_q;
    end
    assign o_si = o_cs_b ? idle_q : si_q;

    // ------------------------------------------
    // one framed transfer, msb first
    // ------------------------------------------
    task automatic frame(input int n, input logic [7:0] tx [8],
        input logic mode3, input int pause, output logic [7:0] rx [8]);
        o_sck <= mode3;
        #HALF;
        o_cs_b <= 1'b0;
        #HALF;
        for (int b = 0; b < n; b++) begin
            for (int k = 7; k >= 0; k--) begin
                o_sck <= 1'b0;
                si_q <= tx[b][k];
                #HALF;
                if (b * 8 + 7 - k == pause) begin
                    o_hold_b <= 1'b0;
                    #HALF;
                    o_sck <= 1'b1;
                    #HALF;
                    o_sck <= 1'b0;
                    #HALF;
                    o_hold_b <= 1'b1;
                    #HALF;
                end
                o_sck <= 1'b1;
                rx[b][k] = i_so_oe ? i_so : 1'bx;
                #HALF;
            end
        end
        if (!mode3) begin
            o_sck <= 1'b0;
        end
        #HALF;
        o_cs_b <= 1'b1;
        #HALF;
    endtask
endmodule

//--- sim/serial_nvram_spi_front_end_tb.sv
`timescale 1ns/10ps
module serial_nvram_spi_front_end_tb;
    import nvram_pkg::*;

    localparam int LIMIT = 40000;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic cs_b, sck, si, hold_b, wp_b, so, so_oe, standby, overrun;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [7:0] tx [8];
    logic [7:0] rx [8];

    initial begin
        forever #4 i_clk = ~i_clk;
    end

    serial_nvram_spi_front_end u_serial_nvram_spi_front_end (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_cs_b(cs_b), .i_sck(sck),
        .i_si(si), .i_hold_b(hold_b), .i_wp_b(wp_b), .o_so(so),
        .o_so_oe(so_oe), .o_standby(standby), .o_overrun(overrun));

    spi_host_model u_spi_host_model (
        .i_clk(i_clk), .i_so(so), .i_so_oe(so_oe), .o_cs_b(cs_b),
        .o_sck(sck), .o_si(si), .o_hold_b(hold_b), .o_wp_b(wp_b));

    // ------------------------------------------
    // compare and report
    // ------------------------------------------
    task automatic check8(input string name, input logic [7:0] exp,
        input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check1(input string name, input logic exp,
        input logic got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errors++;
            print_verdict();
        end
    end

    // ------------------------------------------
    // frame helpers
    // ------------------------------------------
    task automatic send(input int n, input logic mode3, input int pause);
        u_spi_host_model.frame(n, tx, mode3, pause, rx);
    endtask

    task automatic cmd(input logic [7:0] op, input int n);
        tx[0] = op;
        send(n, 1'b0, -1);
    endtask

    // upper address bits set on purpose: they must be ignored
    task automatic wr(input logic [12:0] a, input logic [7:0] d0,
        input logic [7:0] d1, input int n, input int pause);
        tx = '{OP_WRITE, {3'h7, a[12:8]}, a[7:0], d0, d1, 8'h00, 8'h00,
            8'h00};
        send(n + 3, 1'b0, pause);
    endtask

    task automatic rd(input logic [12:0] a, input int n,
        input logic mode3, input int pause);
        tx = '{OP_READ, {3'h0, a[12:8]}, a[7:0], 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00};
        send(n + 3, mode3, pause);
    endtask

    // ------------------------------------------
    // scenarios
    // ------------------------------------------
    task automatic t_idle();
        check1("standby", 1'b1, standby);
        check1("so_oe", 1'b0, so_oe);
    endtask

    task automatic t_wrap();
        cmd(OP_WREN, 1);
        wr(13'h1ffe, 8'ha5, 8'h3c, 2, -1);
        rd(13'h1ffe, 2, 1'b1, -1);
        check8("rd_1ffe", 8'ha5, rx[3]);
        check8("rd_1fff", 8'h3c, rx[4]);
        wr(13'h0000, 8'h96, 8'h00, 1, -1);
        rd(13'h1fff, 2, 1'b0, -1);
        check8("rd_wrap", 8'h96, rx[4]);
        check8("rd_mode0", 8'h3c, rx[3]);
    endtask

    task automatic t_status();
        cmd(OP_RDSR, 3);
        check8("sr_wel", 8'h02, rx[1]);
        check8("sr_again", 8'h02, rx[2]);
        cmd(OP_WRDI, 1);
        cmd(OP_RDSR, 2);
        check8("sr_clear", 8'h00, rx[1]);
        wr(13'h1ffe, 8'h11, 8'h00, 1, -1);
        rd(13'h1ffe, 1, 1'b1, -1);
        check8("wr_no_wel", 8'ha5, rx[3]);
    endtask

    task automatic t_protect();
        cmd(OP_WREN, 1);
        tx[1] = 8'h84;
        cmd(OP_WRSR, 2);
        cmd(OP_RDSR, 2);
        check8("sr_bp", 8'h86, rx[1]);
        wr(13'h1fff, 8'h77, 8'h44, 2, -1);
        rd(13'h1fff, 2, 1'b0, -1);
        check8("bp_keep", 8'h3c, rx[3]);
        check8("bp_open", 8'h44, rx[4]);
        // armed protect pin held low refuses a status write
        u_spi_host_model.o_wp_b <= 1'b0;
        tx[1] = 8'h00;
        cmd(OP_WRSR, 2);
        cmd(OP_RDSR, 2);
        check8("sr_wp_lock", 8'h86, rx[1]);
        u_spi_host_model.o_wp_b <= 1'b1;
        cmd(OP_WRSR, 2);
        cmd(OP_RDSR, 2);
        check8("sr_wp_open", 8'h02, rx[1]);
    endtask

    task automatic t_hold();
        wr(13'h0123, 8'hc9, 8'h00, 1, 27);
        rd(13'h0123, 1, 1'b0, 12);
        check8("hold_wr", 8'hc9, rx[3]);
        check1("standby_end", 1'b1, standby);
        check1("overrun", 1'b0, overrun);
    endtask

    initial begin
        repeat (4) @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (8) @(posedge i_clk);
        t_idle();
        t_wrap();
        t_status();
        t_protect();
        t_hold();
        print_verdict();
    end
endmodule
